// >>> core/sct_map.svh
// Register map, field positions and reset values of the capture/compare timer.
// Assumes byte addresses on a 32-bit classic Wishbone bus, one word per register.
`ifndef SCT_MAP_SVH
`define SCT_MAP_SVH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define SCT_OFS_COUNT 8'h00
`define SCT_OFS_CC_FIRST 8'h04
`define SCT_OFS_CC_SECOND 8'h08
`define SCT_OFS_MODE 8'h0C
`define SCT_OFS_CC_CTL 8'h10
`define SCT_OFS_OUT_CTL 8'h14
`define SCT_OFS_PRESCALE 8'h18
`define SCT_OFS_PORT 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCT_MODE_OVF 0
`define SCT_CC_FIRST_ROLE 0
`define SCT_CC_FIRST_TRIG 1
`define SCT_CC_SECOND_ROLE 2
`define SCT_OUT_ENABLE 0
`define SCT_OUT_TOG_FIRST 1
`define SCT_OUT_LEVEL_RESET 2
`define SCT_OUT_LEVEL_SET 3
`define SCT_OUT_TOG_SECOND 4
`define SCT_OUT_ONESHOT_EN 5
`define SCT_OUT_ONESHOT_TRIG 6
`define SCT_PORT_LATCH 0
`define SCT_PORT_DIR 1

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define SCT_EDGE_FALL 2'h0
`define SCT_EDGE_RISE 2'h1
`define SCT_EDGE_BOTH 2'h3
`define SCT_CLK_DIV2 3'h0
`define SCT_CLK_DIV16 3'h1
`define SCT_CLK_AUX 3'h2
`define SCT_CLK_EVENT 3'h3
`define SCT_CLK_DIV4 3'h4
`define SCT_CLK_DIV64 3'h5
`define SCT_CLK_DIV256 3'h6
`define SCT_COUNT_MAX 16'hFFFF
`define SCT_COUNT_ONE 16'h0001
`define SCT_PORT_DIR_RESET 1'b1

`endif

// >>> core/sct_pkg.sv
// Types of the capture/compare timer.
// Assumes the map header supplies every numeric constant.
package sct_pkg;

  typedef enum logic [1:0] {
    SCT_STOP,
    SCT_FREE,
    SCT_EDGE_CLR,
    SCT_MATCH_CLR
  } sct_mode_type;

  typedef struct packed {
    logic syncA1;
    logic syncA2;
    logic syncB1;
    logic syncB2;
    logic [2:0] fltA;
    logic [2:0] fltB;
    logic lvlA;
    logic lvlB;
    logic [7:0] div;
    logic pend;
    logic [15:0] count;
    logic [15:0] ccFirst;
    logic [15:0] ccSecond;
    logic [2:0] mode;
    logic ovf;
    logic [2:0] ccCtl;
    logic outEnable;
    logic togFirst;
    logic togSecond;
    logic oneshotEn;
    logic [3:0] edgeSel;
    logic [2:0] clkSel;
    logic latch;
    logic dir;
    logic outFf;
    logic irqA;
    logic irqB;
    logic ack;
    logic [31:0] dat;
    logic pinOut;
    logic pinOe;
  } sct_state_type;

endpackage : sct_pkg

// >>> core/sct_timer.sv
// 16-bit up counter with two capture/compare registers and one timer output.
// Assumes a 125 MHz clock, a classic Wishbone master and asynchronous trigger pins.
//
// Operation
// R1 - Read-only 16-bit count, increments per count clock
// R2 - Count read holds off count clock briefly
// R3 - Count clears on reset, stop, edge, match, one-shot
// R4 - Control bit 0 sets first register role
// R5 - First compare match raises first interrupt
// R6 - First capture from either trigger pin
// R7 - Input A trigger captures on opposite edge
// R8 - Input B trigger captures on selected edges
// R9 - Compare registers take full 16-bit writes only
// R10 - Software loads first register nonzero
// R11 - Zero first register interrupts after wrap
// R12 - Control bit 2 sets second register role
// R13 - Second compare match raises second interrupt
// R14 - Second capture on input A valid edge
// R15 - Zero second register interrupts after wrap
// R16 - Pin is port latch ORed with output
// R17 - Input A filtered before edge detection
// R18 - Mode bits pick stop, free, edge, match
// R19 - Control bit picks first capture trigger
// R20 - Match toggles enabled, disabled output forced low
// R21 - Free run wraps FFFFH to 0000H
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "sct_map.svh"

module sct_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic triggerInputA,
  input wire logic triggerInputB,
  output logic matchCaptureIrqA,
  output logic matchCaptureIrqB,
  output logic timerOutputPin,
  output logic timerOutputPinOe
);

  sct_pkg::sct_state_type q;
  sct_pkg::sct_state_type n;
  sct_pkg::sct_mode_type curMode;

  logic acc;
  logic wr;
  logic countRead;
  logic riseA;
  logic fallA;
  logic riseB;
  logic fallB;
  logic validA;
  logic capTrigA;
  logic validB;
  logic tick;
  logic tickEff;
  logic running;
  logic clrEdge;
  logic softShot;
  logic clrMatch;
  logic matchFirst;
  logic matchSecond;
  logic capFirst;
  logic capSecond;
  logic setOvf;
  logic [15:0] incr;
  logic [15:0] nextCount;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign acc = cyc_i && stb_i && !q.ack;
  // Writes land at the edge where the master samples ack
  assign wr = cyc_i && stb_i && q.ack && we_i;
  assign countRead = acc && !we_i && adr_i == `SCT_OFS_COUNT;

  // ----------------------------------------
  // Filtered edges
  // ----------------------------------------
  assign riseA = (&q.fltA) && !q.lvlA; // [R17]
  assign fallA = !(|q.fltA) && q.lvlA; // [R17]
  assign riseB = (&q.fltB) && !q.lvlB;
  assign fallB = !(|q.fltB) && q.lvlB;

  always_comb begin
    unique case (q.edgeSel[1:0])
      `SCT_EDGE_FALL: begin
        validA = fallA;
        capTrigA = riseA; // [R7]
      end
      `SCT_EDGE_RISE: begin
        validA = riseA;
        capTrigA = fallA; // [R7]
      end
      `SCT_EDGE_BOTH: begin
        validA = riseA || fallA;
        capTrigA = 1'b0; // [R7]
      end
      default: begin
        validA = 1'b0;
        capTrigA = 1'b0;
      end
    endcase
    unique case (q.edgeSel[3:2])
      `SCT_EDGE_FALL: validB = fallB; // [R8]
      `SCT_EDGE_RISE: validB = riseB; // [R8]
      `SCT_EDGE_BOTH: validB = riseB || fallB; // [R8]
      default: validB = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Count clock select
  // ----------------------------------------
  always_comb begin
    unique case (q.clkSel)
      `SCT_CLK_DIV2: tick = q.div[0];
      `SCT_CLK_DIV16: tick = &q.div[3:0];
      `SCT_CLK_AUX: tick = q.div[0];
      `SCT_CLK_EVENT: tick = validA; // [R17]
      `SCT_CLK_DIV4: tick = &q.div[1:0];
      `SCT_CLK_DIV64: tick = &q.div[5:0];
      `SCT_CLK_DIV256: tick = &q.div[7:0];
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Counter control
  // ----------------------------------------
  assign curMode = sct_pkg::sct_mode_type'(q.mode[2:1]);
  assign running = curMode != sct_pkg::SCT_STOP; // [R18]
  assign tickEff = (tick || q.pend) && !countRead; // [R2]
  assign incr = 16'(q.count + `SCT_COUNT_ONE);
  assign softShot = wr && sel_i[0] && adr_i == `SCT_OFS_OUT_CTL
    && dat_i[`SCT_OUT_ONESHOT_TRIG] && q.oneshotEn;
  assign clrEdge = running && validA
    && (curMode == sct_pkg::SCT_EDGE_CLR || q.oneshotEn); // [R3]
  assign clrMatch = curMode == sct_pkg::SCT_MATCH_CLR && !q.ccCtl[`SCT_CC_FIRST_ROLE]
    && tickEff && q.count == q.ccFirst; // [R3]

  always_comb begin
    if (!running) begin
      nextCount = 16'h0000; // [R3]
    end else if (clrEdge || softShot || clrMatch) begin
      nextCount = 16'h0000; // [R3]
    end else if (tickEff) begin
      nextCount = incr; // [R1] [R21]
    end else begin
      nextCount = q.count;
    end
  end

  assign setOvf = running && tickEff && q.count == `SCT_COUNT_MAX
    && !clrEdge && !softShot && !clrMatch;

  // ----------------------------------------
  // Compare and capture events
  // ----------------------------------------
  assign matchFirst = !q.ccCtl[`SCT_CC_FIRST_ROLE] && running && tickEff
    && !clrEdge && !softShot
    && (clrMatch || (curMode != sct_pkg::SCT_MATCH_CLR
    && nextCount == q.ccFirst)); // [R4] [R5] [R11]
  assign matchSecond = !q.ccCtl[`SCT_CC_SECOND_ROLE] && running && tickEff
    && !clrEdge && !softShot && nextCount == q.ccSecond; // [R12] [R13] [R15]
  assign capFirst = q.ccCtl[`SCT_CC_FIRST_ROLE] && running
    && (q.ccCtl[`SCT_CC_FIRST_TRIG] ? capTrigA : validB); // [R6] [R19]
  assign capSecond = q.ccCtl[`SCT_CC_SECOND_ROLE] && running && validA; // [R14]

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.syncA1 = triggerInputA;
    n.syncA2 = q.syncA1;
    n.syncB1 = triggerInputB;
    n.syncB2 = q.syncB1;
    n.fltA = {q.fltA[1:0], q.syncA2}; // [R17]
    n.fltB = {q.fltB[1:0], q.syncB2};
    if (riseA) begin
      n.lvlA = 1'b1;
    end else if (fallA) begin
      n.lvlA = 1'b0;
    end
    if (riseB) begin
      n.lvlB = 1'b1;
    end else if (fallB) begin
      n.lvlB = 1'b0;
    end
    n.div = 8'(q.div + 8'h01);
    n.pend = (tick || q.pend) && countRead; // [R2]
    n.count = nextCount;
    n.ovf = setOvf || q.ovf;
    if (capFirst) begin
      n.ccFirst = q.count; // [R6]
    end
    if (capSecond) begin
      n.ccSecond = q.count; // [R14]
    end
    n.irqA = matchFirst || capFirst; // [R5]
    n.irqB = matchSecond || capSecond; // [R13]
    n.outFf = q.outFf ^ (matchFirst && q.togFirst) ^ (matchSecond && q.togSecond)
      ^ (validA && running && q.mode[0]); // [R18] [R20]
    n.ack = acc;
    n.dat = 32'h0000_0000;
    if (acc && !we_i) begin
      unique case (adr_i)
        `SCT_OFS_COUNT: n.dat = {16'h0000, q.count}; // [R1]
        `SCT_OFS_CC_FIRST: n.dat = {16'h0000, q.ccFirst};
        `SCT_OFS_CC_SECOND: n.dat = {16'h0000, q.ccSecond};
        `SCT_OFS_MODE: n.dat = {28'h000_0000, q.mode, q.ovf};
        `SCT_OFS_CC_CTL: n.dat = {29'h0000_0000, q.ccCtl};
        `SCT_OFS_OUT_CTL: n.dat = {26'h000_0000, q.oneshotEn, q.togSecond, 2'h0,
          q.togFirst, q.outEnable};
        `SCT_OFS_PRESCALE: n.dat = {24'h00_0000, q.edgeSel, 1'b0, q.clkSel};
        `SCT_OFS_PORT: n.dat = {30'h0000_0000, q.dir, q.latch};
        default: n.dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (adr_i)
        `SCT_OFS_CC_FIRST: begin
          if (sel_i[1:0] == 2'h3) begin
            n.ccFirst = dat_i[15:0]; // [R9]
          end
        end
        `SCT_OFS_CC_SECOND: begin
          if (sel_i[1:0] == 2'h3) begin
            n.ccSecond = dat_i[15:0]; // [R9]
          end
        end
        `SCT_OFS_MODE: begin
          if (sel_i[0]) begin
            n.mode = dat_i[3:1]; // [R18]
            n.ovf = setOvf || (q.ovf && dat_i[`SCT_MODE_OVF]);
          end
        end
        `SCT_OFS_CC_CTL: begin
          if (sel_i[0]) begin
            n.ccCtl = dat_i[2:0]; // [R4] [R12] [R19]
          end
        end
        `SCT_OFS_OUT_CTL: begin
          if (sel_i[0]) begin
            n.outEnable = dat_i[`SCT_OUT_ENABLE];
            n.togFirst = dat_i[`SCT_OUT_TOG_FIRST];
            n.togSecond = dat_i[`SCT_OUT_TOG_SECOND];
            n.oneshotEn = dat_i[`SCT_OUT_ONESHOT_EN];
            if (dat_i[`SCT_OUT_LEVEL_SET] && !dat_i[`SCT_OUT_LEVEL_RESET]) begin
              n.outFf = 1'b1;
            end else if (dat_i[`SCT_OUT_LEVEL_RESET] && !dat_i[`SCT_OUT_LEVEL_SET]) begin
              n.outFf = 1'b0;
            end
          end
        end
        `SCT_OFS_PRESCALE: begin
          if (sel_i[0]) begin
            n.edgeSel = dat_i[7:4];
            n.clkSel = dat_i[2:0];
          end
        end
        `SCT_OFS_PORT: begin
          if (sel_i[0]) begin
            n.latch = dat_i[`SCT_PORT_LATCH];
            n.dir = dat_i[`SCT_PORT_DIR];
          end
        end
        default: begin
        end
      endcase
    end
    n.pinOut = (n.outFf && n.outEnable) || n.latch; // [R16] [R20]
    n.pinOe = !n.dir; // [R16]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.dir <= `SCT_PORT_DIR_RESET;
    end else begin
      q <= n;
    end
  end

  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign matchCaptureIrqA = q.irqA;
  assign matchCaptureIrqB = q.irqB;
  assign timerOutputPin = q.pinOut;
  assign timerOutputPinOe = q.pinOe;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence busReq;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence countReadReq;
    busReq ##0 (!we_i && adr_i == `SCT_OFS_COUNT);
  endsequence

  bus_ack_once_a: assert property (busReq |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle");
  count_hold_a: assert property (countReadReq |=> q.count == $past(q.count) || q.count == 16'h0000) // [R2]
    else $error("count moved during read");
  count_read_a: assert property (countReadReq |=> dat_o == {16'h0000, $past(q.count)}) // [R1]
    else $error("count read value wrong");
  stop_clear_a: assert property (curMode == sct_pkg::SCT_STOP |=> q.count == 16'h0000) // [R3]
    else $error("stopped timer not cleared");
  count_step_a: assert property (running && tickEff && !clrEdge && !softShot && !clrMatch
    |=> q.count == 16'($past(q.count) + 16'h0001)) // [R1]
    else $error("count did not step");
  free_wrap_a: assert property (curMode == sct_pkg::SCT_FREE && q.count == 16'hFFFF
    && tickEff && !clrEdge && !softShot |=> q.count == 16'h0000) // [R21]
    else $error("free run did not wrap");
  edge_clear_a: assert property (clrEdge |=> q.count == 16'h0000) // [R3]
    else $error("edge clear failed");
  first_irq_a: assert property (matchFirst |=> matchCaptureIrqA) // [R5]
    else $error("first match irq missing");
  second_irq_a: assert property (matchSecond |=> matchCaptureIrqB) // [R13]
    else $error("second match irq missing");
  first_cap_a: assert property (capFirst |=> q.ccFirst == $past(q.count)) // [R6]
    else $error("first capture value wrong");
  second_cap_a: assert property (capSecond |=> q.ccSecond == $past(q.count)) // [R14]
    else $error("second capture value wrong");
  half_write_a: assert property (wr && adr_i == `SCT_OFS_CC_FIRST && sel_i[1:0] != 2'h3
    && !capFirst |=> $stable(q.ccFirst)) // [R9]
    else $error("partial write changed register");
  pin_or_a: assert property (##1 timerOutputPin == ((q.outFf && q.outEnable) || q.latch)) // [R16]
    else $error("pin not latch OR output");
  both_edges_a: assert property (q.edgeSel[1:0] == `SCT_EDGE_BOTH
    && q.ccCtl[`SCT_CC_FIRST_TRIG] |-> !capFirst) // [R7]
    else $error("capture with both edges");

endmodule : sct_timer

// >>> sim/sct_pulse_src.sv
// Pulse source model for the two trigger pins of the timer.
// Assumes the bench calls pulse() from one process at a time.
`timescale 1ns/1ps

module sct_pulse_src (
  input wire logic clock,
  output logic pinA,
  output logic pinB
);

  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end

  // ----------------------------------------
  // One high pulse, width w clocks, then w clocks low
  // ----------------------------------------
  task pulse(input logic selA, input int w);
    @(posedge clock);
    if (selA) pinA <= 1'b1; else pinB <= 1'b1;
    repeat (w) @(posedge clock);
    if (selA) pinA <= 1'b0; else pinB <= 1'b0;
    repeat (w) @(posedge clock);
  endtask : pulse

endmodule : sct_pulse_src

// >>> sim/tb_top.sv
// Self-checking bench of the capture/compare timer over classic Wishbone.
// Assumes the map header and the pulse source model are compiled alongside.
`timescale 1ns/1ps
`include "sct_map.svh"

module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h0000_0000;
  logic [31:0] rdDat;
  logic ack;
  logic irqA;
  logic irqB;
  logic pin;
  logic pinOe;
  logic trigA;
  logic trigB;
  logic pinLast = 1'b0;
  logic [31:0] q;
  logic [31:0] q2;
  logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
  int expSel [3] = '{1, 1, 2};
  int expOpp [3] = '{1, 1, 0};
  int error_cnt = 0;
  int n_checks = 0;
  int seenA = 0;
  int seenB = 0;
  int pinEdges = 0;
  int a0;
  int b0;
  int p0;

  always #4 clock = ~clock;

  sct_timer sct_timer_inst (
    .clock(clock),
    .rst(rst),
    .cyc_i(wbCyc),
    .stb_i(wbStb),
    .we_i(wbWe),
    .adr_i(wbAdr),
    .sel_i(wbSel),
    .dat_i(wbDat),
    .dat_o(rdDat),
    .ack_o(ack),
    .triggerInputA(trigA),
    .triggerInputB(trigB),
    .matchCaptureIrqA(irqA),
    .matchCaptureIrqB(irqB),
    .timerOutputPin(pin),
    .timerOutputPinOe(pinOe)
  );

  sct_pulse_src sct_pulse_src_inst (
    .clock(clock),
    .pinA(trigA),
    .pinB(trigB)
  );

  // ----------------------------------------
  // Event counters
  // ----------------------------------------
  always @(posedge clock) begin
    if (irqA === 1'b1) seenA <= seenA + 1;
    if (irqB === 1'b1) seenB <= seenB + 1;
    pinLast <= pin;
    if (pin !== pinLast) pinEdges <= pinEdges + 1;
  end

  // ----------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------
  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [31:0] r);
    logic got;
    got = 1'b0;
    r = 32'h0000_0000;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDat <= d;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clock);
      if (ack === 1'b1) begin
        got = 1'b1;
        r = rdDat;
      end
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (!got) begin
      error_cnt++;
      $display("mismatch bus ack expected 1 seen 0");
      results();
    end
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, 4'hF, dummy);
  endtask : wr

  task rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, 4'hF, r);
    check(what, exp, r);
  endtask : rdChk

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    $display("mismatch run length expected done seen hang");
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdChk("count reset", `SCT_OFS_COUNT, 32'h0000_0000);
    rdChk("port reset", `SCT_OFS_PORT, 32'h0000_0002);
    rdChk("mode reset", `SCT_OFS_MODE, 32'h0000_0000);
    rdChk("unmapped read", 8'h40, 32'h0000_0000);
    check("pin drive reset", 32'h0000_0000, {31'h0, pinOe});
    check("pin reset", 32'h0000_0000, {31'h0, pin});
    $display("test reset done");

    wr(`SCT_OFS_CC_FIRST, 32'h0000_1234);
    xfer(1'b1, `SCT_OFS_CC_FIRST, 32'hFFFF_FFFF, 4'h1, q);
    rdChk("cc first partial", `SCT_OFS_CC_FIRST, 32'h0000_1234);
    wr(`SCT_OFS_COUNT, 32'h0000_0055);
    rdChk("count read only", `SCT_OFS_COUNT, 32'h0000_0000);
    $display("test registers done");

    wr(`SCT_OFS_CC_FIRST, 32'h0000_0004);
    wr(`SCT_OFS_CC_SECOND, 32'h0000_0002);
    wr(`SCT_OFS_PORT, 32'h0000_0000);
    wr(`SCT_OFS_OUT_CTL, 32'h0000_0013);
    wr(`SCT_OFS_PRESCALE, 32'h0000_0000);
    wr(`SCT_OFS_MODE, 32'h0000_000C);
    repeat (20) @(posedge clock);
    a0 = seenA;
    b0 = seenB;
    p0 = pinEdges;
    repeat (100) @(posedge clock);
    check("first match irqs", 32'h0000_000A, 32'(seenA - a0));
    check("second match irqs", 32'h0000_000A, 32'(seenB - b0));
    check("output toggles", 32'h0000_0014, 32'(pinEdges - p0));
    check("pin drive enable", 32'h0000_0001, {31'h0, pinOe});
    wr(`SCT_OFS_OUT_CTL, 32'h0000_0012);
    repeat (4) @(posedge clock);
    check("pin disabled", 32'h0000_0000, {31'h0, pin});
    wr(`SCT_OFS_PORT, 32'h0000_0001);
    repeat (4) @(posedge clock);
    check("pin port latch", 32'h0000_0001, {31'h0, pin});
    wr(`SCT_OFS_PORT, 32'h0000_0000);
    wr(`SCT_OFS_MODE, 32'h0000_0000);
    rdChk("count stopped", `SCT_OFS_COUNT, 32'h0000_0000);
    $display("test interval done");

    wr(`SCT_OFS_MODE, 32'h0000_0004);
    xfer(1'b0, `SCT_OFS_COUNT, 32'h0000_0000, 4'hF, q);
    repeat (50) @(posedge clock);
    xfer(1'b0, `SCT_OFS_COUNT, 32'h0000_0000, 4'hF, q2);
    check("count advance", 32'h0000_0001, {31'h0, (q2 - q) inside {[24:28]}});
    $display("test count done");

    for (int k = 0; k < 3; k++) begin
      for (int t = 0; t < 2; t++) begin
        wr(`SCT_OFS_MODE, 32'h0000_0000);
        wr(`SCT_OFS_PRESCALE, {24'h0, codes[k], codes[k], 4'h0});
        wr(`SCT_OFS_CC_CTL, (t == 1) ? 32'h0000_0007 : 32'h0000_0005);
        wr(`SCT_OFS_MODE, 32'h0000_0004);
        a0 = seenA;
        sct_pulse_src_inst.pulse(1'b0, 8);
        repeat (10) @(posedge clock);
        check("capture by b", 32'((t == 1) ? 0 : expSel[k]), 32'(seenA - a0));
        a0 = seenA;
        b0 = seenB;
        sct_pulse_src_inst.pulse(1'b1, 8);
        repeat (10) @(posedge clock);
        check("capture by a", 32'((t == 1) ? expOpp[k] : 0), 32'(seenA - a0));
        check("second capture", 32'(expSel[k]), 32'(seenB - b0));
      end
    end
    $display("test capture done");

    wr(`SCT_OFS_MODE, 32'h0000_0000);
    wr(`SCT_OFS_PRESCALE, 32'h0000_0010);
    wr(`SCT_OFS_CC_CTL, 32'h0000_0000);
    wr(`SCT_OFS_CC_FIRST, 32'h0000_FFFF);
    wr(`SCT_OFS_CC_SECOND, 32'h0000_FFFF);
    wr(`SCT_OFS_MODE, 32'h0000_0008);
    repeat (200) @(posedge clock);
    sct_pulse_src_inst.pulse(1'b1, 4);
    xfer(1'b0, `SCT_OFS_COUNT, 32'h0000_0000, 4'hF, q);
    check("count after edge clear", 32'h0000_0001, {31'h0, q < 32'h0000_0008});
    $display("test edge clear done");

    wr(`SCT_OFS_MODE, 32'h0000_0000);
    wr(`SCT_OFS_PRESCALE, 32'h0000_0013);
    wr(`SCT_OFS_CC_FIRST, 32'h0000_0002);
    wr(`SCT_OFS_OUT_CTL, 32'h0000_0001);
    wr(`SCT_OFS_MODE, 32'h0000_0006);
    a0 = seenA;
    p0 = pinEdges;
    repeat (3) sct_pulse_src_inst.pulse(1'b1, 4);
    repeat (10) @(posedge clock);
    rdChk("event count", `SCT_OFS_COUNT, 32'h0000_0003);
    check("event match irq", 32'h0000_0001, 32'(seenA - a0));
    check("edge toggles", 32'h0000_0003, 32'(pinEdges - p0));
    $display("test event count done");

    wr(`SCT_OFS_MODE, 32'h0000_0000);
    wr(`SCT_OFS_PRESCALE, 32'h0000_0010);
    wr(`SCT_OFS_OUT_CTL, 32'h0000_0021);
    wr(`SCT_OFS_MODE, 32'h0000_0004);
    repeat (100) @(posedge clock);
    wr(`SCT_OFS_OUT_CTL, 32'h0000_0061);
    xfer(1'b0, `SCT_OFS_COUNT, 32'h0000_0000, 4'hF, q);
    check("count after soft shot", 32'h0000_0001, {31'h0, q < 32'h0000_0008});
    rdChk("soft shot reads zero", `SCT_OFS_OUT_CTL, 32'h0000_0021);
    repeat (100) @(posedge clock);
    sct_pulse_src_inst.pulse(1'b1, 4);
    xfer(1'b0, `SCT_OFS_COUNT, 32'h0000_0000, 4'hF, q);
    check("count after shot edge", 32'h0000_0001, {31'h0, q < 32'h0000_0008});
    $display("test one shot done");
    results();
  end

endmodule : tb_top
